//--- src/rxe_rx_align.sv
`timescale 1ns/10ps
module rxe_rx_align
  import rxe_pkg::*;
#(
  parameter int AW = 3 // buffer address width, depth 2**AW
) (
  input logic sys_clk, // selected word clock
  input logic rst, // synchronous, active high
  input logic rec_clk [NCH], // recovered character clocks
  input rxe_dec_t dec_char [NCH], // decoder output per channel
  input logic comma_realign [NCH], // comma moved framing, pulse
  input rxe_fsm_t sync_loss_fsm [NCH], // sync state machine state
  input logic freq_locked_in, // pin, high turns rate match off
  input logic align_sync_in, // pin, sync code input
  input logic [1:0] rx_timing_select, // output timing select strap
  input logic dual_edge, // strap, both edges of word clock
  input logic tx_skew_buf_error_in [NCH], // raw skew buffer errors
  input logic primary_sig_detect_in [NCH], // raw primary detect
  input logic redundant_sig_detect_in [NCH], // raw redundant detect
  output logic [7:0] rx_byte [NCH], // received data
  output logic rx_error_flag [NCH], // status bit 2
  output logic rx_control_char_flag [NCH], // status bit 1
  output logic rx_idle_flag [NCH], // status bit 0
  output logic tx_skew_buf_error [NCH], // retimed
  output logic primary_sig_detect [NCH], // retimed
  output logic redundant_sig_detect [NCH], // retimed
  output logic chan_recovered_clk_pair [NCH], // true clock out
  output logic chan_recovered_clk_pair_n [NCH], // complement out
  output logic align_sync_out // serial sync code out
);
  localparam int DEPTH = 1 << AW;
  localparam logic [AW-1:0] HALF = AW'(DEPTH / 2);
  localparam logic [AW-1:0] HI_TH = HALF + AW'(MATCH_MARGIN);
  localparam logic [AW-1:0] LO_TH = HALF - AW'(MATCH_MARGIN);
  localparam logic [AW-1:0] ADV = AW'(ALIGN_ADV);

  function automatic logic [AW-1:0] gray2bin(input logic [AW-1:0] g);
    logic [AW-1:0] b;
    b[AW-1] = g[AW-1];
    for (int k = AW - 2; k >= 0; k--) begin
      b[k] = b[k+1] ^ g[k];
    end
    return b;
  endfunction

  // ==========================================================
  // pins into the word clock domain
  logic flk1, flk, si1, si2;
  logic [2:0] pin1 [NCH];
  logic [2:0] pin2 [NCH];
  always_ff @(posedge sys_clk) begin
    flk1 <= freq_locked_in;
    flk <= flk1;
    si1 <= align_sync_in;
    si2 <= si1;
  end

  // ==========================================================
  // sync input receiver and mode decision
  rxe_si_t si_st;
  logic si_b1;
  logic [2:0] one_run;
  logic indep, aligned, code_ws, code_del, code_ins;
  wire held_high = (one_run >= HIGH_RUN);
  wire rm_ind = !flk && indep;
  wire rm_al = !flk && aligned && !indep;

  // count of consecutive ones tells a held-high pin from codes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      one_run <= 3'h0;
      indep <= 1'b0;
      aligned <= 1'b0;
    end else begin
      one_run <= si2 ? (held_high ? one_run : one_run + 3'h1) : 3'h0;
      indep <= held_high;
      if (held_high) aligned <= 1'b0;
      else if (code_ws) aligned <= 1'b1;
    end
  end

  // three-bit code: start 1, then two bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      si_st <= SI_WAIT;
      si_b1 <= 1'b0;
      code_ws <= 1'b0;
      code_del <= 1'b0;
      code_ins <= 1'b0;
    end else begin
      code_ws <= 1'b0;
      code_del <= 1'b0;
      code_ins <= 1'b0;
      case (si_st)
        SI_WAIT: if (si2) si_st <= SI_B1;
        SI_B1: begin
          si_b1 <= si2;
          si_st <= SI_B2;
        end
        SI_B2: begin
          si_st <= SI_WAIT;
          code_ws <= !si_b1 && si2;
          code_del <= si_b1 && !si2;
          code_ins <= si_b1 && si2 && !held_high;
        end
        default: si_st <= SI_WAIT;
      endcase
    end
  end

  // ==========================================================
  // per-channel arrays shared with the master and checks
  logic [AW-1:0] rptr [NCH];
  logic [AW-1:0] wbin [NCH];
  logic need_del [NCH];
  logic need_ins [NCH];
  logic pt_ev [NCH];
  logic do_del [NCH];
  logic do_ins [NCH];
  logic rc_do [NCH];
  logic rc_req [NCH];
  logic [2:0] st_out [NCH];

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // ========================================================
    // write side on the channel recovered clock
    logic rs1, rs2, pt_tog, re_tog, clk_div;
    logic [AW-1:0] wptr, wgray, pt_addr;
    logic [3:0] h_idle, h_neg;
    logic [ENT_W-1:0] mem [DEPTH];
    logic [2:0] st_w;
    rxe_ent_t ent_w;
    wire is_idle = dec_char[i].k && (dec_char[i].data == IDLE_BYTE);
    wire [3:0] n_idle = {h_idle[2:0], is_idle};
    wire [3:0] n_neg = {h_neg[2:0], dec_char[i].rd_neg};
    wire pt_hit = (&n_idle) && (n_neg == 4'h3 || n_neg == 4'hc);

    // priority merge of decoder and sync state
    assign st_w = (sync_loss_fsm[i] == FSM_LOSS) ? ST_LOSS :
      dec_char[i].code_bad ? ST_OOB :
      dec_char[i].disp_bad ? ST_DISP :
      (sync_loss_fsm[i] == FSM_RESYNC) ? ST_RESYNC :
      is_idle ? ST_IDLE : dec_char[i].k ? ST_KCHAR : ST_DATA;
    assign ent_w = '{data: dec_char[i].data, st: st_w, rd_neg: dec_char[i].rd_neg};

    // reset reaches this domain through two flops
    always_ff @(posedge rec_clk[i]) begin
      rs1 <= rst;
      rs2 <= rs1;
    end

    // every rising recovered clock edge writes one character
    always_ff @(posedge rec_clk[i]) begin
      mem[wptr] <= ent_w;
      if (rs2) begin
        wptr <= '0;
        wgray <= '0;
        h_idle <= 4'h0;
        h_neg <= 4'h0;
        pt_tog <= 1'b0;
        re_tog <= 1'b0;
        pt_addr <= '0;
        clk_div <= 1'b0;
      end else begin
        wptr <= wptr + AW'(1);
        wgray <= (wptr + AW'(1)) ^ ((wptr + AW'(1)) >> 1);
        h_idle <= n_idle;
        h_neg <= n_neg;
        clk_div <= !clk_div; // half rate for dual edge
        if (comma_realign[i]) re_tog <= !re_tog;
        if (pt_hit) begin
          pt_tog <= !pt_tog;
          pt_addr <= wptr; // held until the next point
        end
      end
    end

    // clock pair out; a strap select, so glitches only at setup
    wire own_clk = dual_edge ? clk_div : rec_clk[i];
    wire a_clk = dual_edge ? g_ch[0].clk_div : rec_clk[0];
    wire sel_clk = rx_timing_select[0] ? own_clk : a_clk;
    assign chan_recovered_clk_pair[i] = rx_timing_select[1] && sel_clk;
    assign chan_recovered_clk_pair_n[i] = !(rx_timing_select[1] && sel_clk);

    // ========================================================
    // read side on the word clock
    logic [AW-1:0] wg1, wg2, pt_rd;
    logic pt1, pt2, pt3, re1, re2, re3, err_q, del_pend, ins_pend;
    rxe_ent_t cur;
    assign wbin[i] = gray2bin(wg2);
    assign cur = rxe_ent_t'(mem[rptr[i]]);
    wire [AW-1:0] occ = wbin[i] - rptr[i];
    wire cur_idle = (cur.st == ST_IDLE);
    wire re_ev = re2 ^ re3;
    wire al_do = aligned && code_ws;
    assign pt_ev[i] = pt2 ^ pt3;
    assign need_del[i] = (occ > HI_TH);
    assign need_ins[i] = (occ < LO_TH);
    assign rc_do[i] = rc_req[i] || re_ev || (pt_ev[i] && !aligned);
    assign do_del[i] = !rc_do[i] && !al_do && cur_idle && !err_q &&
      ((rm_ind && need_del[i]) || (rm_al && del_pend));
    assign do_ins[i] = !rc_do[i] && !al_do && cur_idle && !err_q &&
      ((rm_ind && need_ins[i]) || (rm_al && ins_pend));

    // crossings: gray pointer, two event toggles and the status pins
    always_ff @(posedge sys_clk) begin
      wg1 <= wgray;
      wg2 <= wg1;
      {pt1, pt2, pt3} <= {pt_tog, pt1, pt2};
      {re1, re2, re3} <= {re_tog, re1, re2};
      pin1[i] <= {tx_skew_buf_error_in[i], primary_sig_detect_in[i],
                  redundant_sig_detect_in[i]};
      pin2[i] <= pin1[i];
    end

    // pointer moves: recenter, align, delete, hold or step
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        rptr[i] <= '0;
        rc_req[i] <= 1'b1;
        pt_rd <= '0;
        err_q <= 1'b0;
        del_pend <= 1'b0;
        ins_pend <= 1'b0;
      end else begin
        rc_req[i] <= 1'b0;
        if (pt_ev[i]) pt_rd <= g_ch[i].pt_addr; // stable two cycles by now
        if (rc_do[i]) rptr[i] <= wbin[i] - HALF;
        else if (al_do) rptr[i] <= pt_rd + ADV;
        else if (do_del[i]) rptr[i] <= rptr[i] + AW'(2);
        else if (!do_ins[i]) rptr[i] <= rptr[i] + AW'(1);
        err_q <= do_del[i] || do_ins[i];
        // code arrives before the idle; cleared once acted upon
        if (code_del && rm_al) del_pend <= 1'b1;
        else if (do_del[i] || !rm_al) del_pend <= 1'b0;
        if (code_ins && rm_al) ins_pend <= 1'b1;
        else if (do_ins[i] || !rm_al) ins_pend <= 1'b0;
      end
    end

    // output registers; loss outranks the buffer error
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        rx_byte[i] <= 8'h00;
        st_out[i] <= ST_DATA;
        tx_skew_buf_error[i] <= 1'b0;
        primary_sig_detect[i] <= 1'b0;
        redundant_sig_detect[i] <= 1'b0;
      end else begin
        rx_byte[i] <= cur.data; // one character per word clock edge
        st_out[i] <= (err_q && cur.st != ST_LOSS) ? ST_BUFERR : cur.st;
        {tx_skew_buf_error[i], primary_sig_detect[i],
         redundant_sig_detect[i]} <= pin2[i];
      end
    end
    assign rx_error_flag[i] = st_out[i][2];
    assign rx_control_char_flag[i] = st_out[i][1];
    assign rx_idle_flag[i] = st_out[i][0];
  end

  // ==========================================================
  // sync code master driven by channel A
  logic [3:0] so_sr, hold;
  assign align_sync_out = so_sr[3];
  wire so_free = (so_sr == 4'h0) && (hold == 4'h0);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      so_sr <= 4'h0;
      hold <= 4'h0;
    end else if (so_free && pt_ev[0]) begin
      so_sr <= SR_WSYNC;
      hold <= HOLDOFF;
    end else if (so_free && rm_al && need_del[0]) begin
      so_sr <= SR_DEL;
      hold <= HOLDOFF;
    end else if (so_free && rm_al && need_ins[0]) begin
      so_sr <= SR_INS;
      hold <= HOLDOFF;
    end else begin
      so_sr <= {so_sr[2:0], 1'b0};
      if (hold != 4'h0) hold <= hold - 4'h1;
    end
  end

  // ==========================================================
  // checks on the word clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_rst_recenter: assert property ($fell(rst) |-> rc_do[0] ##1
    rptr[0] == $past(wbin[0]) - HALF) else $error("no recenter after reset");
  a_half_behind: assert property (rc_do[1] |=>
    rptr[1] == $past(wbin[1]) - HALF) else $error("recenter not half depth");
  a_underrun_mark: assert property (do_ins[0] |=>
    (rptr[0] == $past(rptr[0])) ##1 (st_out[0] == ST_BUFERR || st_out[0] == ST_LOSS))
    else $error("underrun not marked on duplicate");
  a_overrun_mark: assert property (do_del[2] |=>
    (rptr[2] == $past(rptr[2]) + AW'(2)) ##1 st_out[2][2:1] == 2'h3)
    else $error("overrun not marked");
  a_locked_no_match: assert property (flk |-> !do_del[3] && !do_ins[3])
    else $error("rate match while locked");
  a_idle_only: assert property ((do_del[0] || do_ins[0]) |->
    g_ch[0].cur.st == ST_IDLE) else $error("non-idle moved");
  a_clk_held: assert property (!rx_timing_select[1] |->
    !chan_recovered_clk_pair[1] && chan_recovered_clk_pair_n[1])
    else $error("clock pair not held");
  a_sig_det_time: assert property (!rst [*4] |->
    primary_sig_detect[0] == $past(primary_sig_detect_in[0], 3))
    else $error("signal detect not retimed");
  a_sync_code: assert property (so_free && pt_ev[0] |=>
    align_sync_out ##1 !align_sync_out ##1 align_sync_out ##1 !align_sync_out)
    else $error("sync code shape wrong");
  a_comma_recenter: assert property ($changed(g_ch[0].re2) && $past(!rst) |=>
    rptr[0] == $past(wbin[0]) - HALF) else $error("comma did not recenter");

  c_insert: cover property (do_ins[0] ##1 do_ins[1]);
  c_delete: cover property (do_del[0]);
  c_align: cover property (aligned && code_ws);
  c_indep: cover property (indep ##[1:20] do_del[1]);
endmodule // rxe_rx_align

//--- src/rxe_pkg.sv
// ==========================================================
// receive alignment constants and carriers
package rxe_pkg;
  localparam int NCH = 4; // receive channels
  localparam int ENT_W = 12; // buffer entry width
  // per-character status codes {err, kch, idle}
  localparam logic [2:0] ST_DATA = 3'h0;
  localparam logic [2:0] ST_IDLE = 3'h1;
  localparam logic [2:0] ST_KCHAR = 3'h2;
  localparam logic [2:0] ST_RESYNC = 3'h3;
  localparam logic [2:0] ST_DISP = 3'h4;
  localparam logic [2:0] ST_OOB = 3'h5;
  localparam logic [2:0] ST_BUFERR = 3'h6;
  localparam logic [2:0] ST_LOSS = 3'h7;
  localparam logic [7:0] IDLE_BYTE = 8'hbc; // comma idle control code
  // serial sync codes, first bit always 1
  localparam logic [3:0] SR_WSYNC = 4'ha; // 1 0 1 then gap
  localparam logic [3:0] SR_DEL = 4'hc; // 1 1 0
  localparam logic [3:0] SR_INS = 4'he; // 1 1 1 then gap
  localparam logic [3:0] HOLDOFF = 4'hf; // hold cycles counted down from each code load
  localparam logic [2:0] HIGH_RUN = 3'h4; // ones that mean input held high
  localparam int MATCH_MARGIN = 1; // fill error before an idle is moved
  localparam int ALIGN_ADV = 2; // read offset past the sync point
  localparam int DRIFT_BITS = 2; // tolerated drift, bit times
  localparam int SKEW_BITS = 6; // tolerated skew, bit times
  // sync state machine states, gray along loss-resync-sync
  typedef enum logic [1:0] {
    FSM_LOSS = 2'h0,
    FSM_RESYNC = 2'h1,
    FSM_SYNC = 2'h3
  } rxe_fsm_t;
  // sync input receiver states
  typedef enum logic [1:0] {
    SI_WAIT = 2'h0,
    SI_B1 = 2'h1,
    SI_B2 = 2'h3
  } rxe_si_t;
  // decoder result per character
  typedef struct packed {
    logic [7:0] data;
    logic k;
    logic code_bad;
    logic disp_bad;
    logic rd_neg;
  } rxe_dec_t;
  // elastic buffer entry
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] st;
    logic rd_neg;
  } rxe_ent_t;
endpackage

//--- testbench/rxe_far_model.sv
`timescale 1ns/10ps
// ==========================================================
// far side: recovered clocks and decoded characters per channel
module rxe_far_model
  import rxe_pkg::*;
(
  input rxe_dec_t tx_char, // next character to present
  input rxe_fsm_t tx_fsm, // sync state to present
  input logic realign, // framing shift, held one recovered period
  output logic rec_clk [NCH], // recovered clocks
  output rxe_dec_t dec_char [NCH], // decoded characters
  output logic comma_realign [NCH], // framing shift from the bench
  output rxe_fsm_t sync_loss_fsm [NCH] // sync state per channel
);
  // free running clocks; small offsets stand in for lane skew
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    initial begin
      rec_clk[i] = 1'b0;
      dec_char[i] = '0;
      sync_loss_fsm[i] = FSM_LOSS;
      #(7 + 2 * i);
      forever #62.5 rec_clk[i] = ~rec_clk[i];
    end
    // one character to every lane at once, so idles come as whole words
    always @(negedge rec_clk[i]) begin
      dec_char[i] <= tx_char;
      sync_loss_fsm[i] <= tx_fsm;
    end
    assign comma_realign[i] = realign;
  end
endmodule // rxe_far_model

//--- testbench/rx_elastic_deskew_rate_match_tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// bench for the receive alignment back end
module rx_elastic_deskew_rate_match_tb_top;
  import rxe_pkg::*;
  typedef struct {
    logic [7:0] d;
    logic k, cb, db;
    rxe_fsm_t f;
    logic chk_d;
    logic [2:0] st;
  } rxe_row_t;
  logic sys_clk = 1'b0, rst = 1'b1, freq_locked_in = 1'b1, align_sync_in = 1'b0;
  logic dual_edge = 1'b0, align_sync_out, realign = 1'b0;
  logic [1:0] rx_timing_select = 2'h3;
  logic rec_clk [NCH], comma_realign [NCH], skew_in [NCH], pri_in [NCH], red_in [NCH];
  logic err_f [NCH], kch_f [NCH], idle_f [NCH], skew_o [NCH], pri_o [NCH], red_o [NCH];
  logic clk_t [NCH], clk_c [NCH];
  logic [7:0] rx_byte [NCH];
  rxe_dec_t dec_char [NCH];
  rxe_fsm_t sync_loss_fsm [NCH];
  rxe_dec_t tx_char = '0;
  rxe_fsm_t tx_fsm = FSM_SYNC;
  int failures = 0, cmp_count = 0, seen;
  // each status row held long enough to fill every buffer slot
  rxe_row_t rows [9] = '{
    '{8'h5a, 1'b0, 1'b0, 1'b0, FSM_SYNC, 1'b1, ST_DATA},
    '{8'ha5, 1'b0, 1'b0, 1'b0, FSM_SYNC, 1'b1, ST_DATA},
    '{IDLE_BYTE, 1'b1, 1'b0, 1'b0, FSM_SYNC, 1'b1, ST_IDLE},
    '{8'hfc, 1'b1, 1'b0, 1'b0, FSM_SYNC, 1'b1, ST_KCHAR},
    '{8'h11, 1'b0, 1'b1, 1'b0, FSM_SYNC, 1'b0, ST_OOB},
    '{8'h22, 1'b0, 1'b0, 1'b1, FSM_SYNC, 1'b0, ST_DISP},
    '{8'h33, 1'b0, 1'b1, 1'b1, FSM_SYNC, 1'b0, ST_OOB},
    '{8'h44, 1'b0, 1'b0, 1'b0, FSM_LOSS, 1'b0, ST_LOSS},
    '{IDLE_BYTE, 1'b1, 1'b0, 1'b0, FSM_RESYNC, 1'b0, ST_RESYNC}
  };
  always #25 sys_clk = ~sys_clk;

  rxe_far_model far_u (.tx_char(tx_char), .tx_fsm(tx_fsm), .realign(realign), .rec_clk(rec_clk),
    .dec_char(dec_char), .comma_realign(comma_realign), .sync_loss_fsm(sync_loss_fsm));
  rxe_rx_align dut_u (.sys_clk(sys_clk), .rst(rst), .rec_clk(rec_clk), .dec_char(dec_char),
    .comma_realign(comma_realign), .sync_loss_fsm(sync_loss_fsm),
    .freq_locked_in(freq_locked_in), .align_sync_in(align_sync_in),
    .rx_timing_select(rx_timing_select), .dual_edge(dual_edge),
    .tx_skew_buf_error_in(skew_in), .primary_sig_detect_in(pri_in),
    .redundant_sig_detect_in(red_in), .rx_byte(rx_byte), .rx_error_flag(err_f),
    .rx_control_char_flag(kch_f), .rx_idle_flag(idle_f), .tx_skew_buf_error(skew_o),
    .primary_sig_detect(pri_o), .redundant_sig_detect(red_o),
    .chan_recovered_clk_pair(clk_t), .chan_recovered_clk_pair_n(clk_c),
    .align_sync_out(align_sync_out));

  // ==========================================================
  // helpers
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic [2:0] st(input int i);
    return {err_f[i], kch_f[i], idle_f[i]};
  endfunction
  function automatic rxe_dec_t mk(input logic [7:0] d, input logic k, cb, db, rn);
    return '{d, k, cb, db, rn};
  endfunction
  // idle stream in a given mode; count buffer error marks on channel a
  task automatic rm_watch(input logic fl, si, input rxe_fsm_t f, input logic exp);
    freq_locked_in = fl;
    align_sync_in = si;
    tx_fsm = f;
    tx_char = mk(IDLE_BYTE, 1'b1, 1'b0, 1'b0, 1'b0);
    cyc(40);
    seen = 0;
    repeat (200) begin
      @(negedge sys_clk);
      if (st(0) === ST_BUFERR) seen++;
    end
    chk_bit(seen > 0, exp);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    foreach (skew_in[i]) begin
      skew_in[i] = 1'b0;
      pri_in[i] = 1'b0;
      red_in[i] = 1'b0;
    end
    cyc(10);
    foreach (rx_byte[i]) begin
      chk_byte(rx_byte[i], 8'h00);
      chk_byte({5'h0, st(i)}, 8'h00);
    end
    chk_bit(align_sync_out, 1'b0);
    rst = 1'b0;
    // pin status retimed: old value after two edges, new after three
    for (int p = 0; p < 2; p++) begin
      foreach (skew_in[i]) begin
        skew_in[i] = p[0] ^ i[0];
        pri_in[i] = ~(p[0] ^ i[0]);
        red_in[i] = p[0] ^ i[0];
      end
      cyc(2);
      foreach (skew_o[i]) chk_bit(skew_o[i], p[0] & i[0]);
      cyc(1);
      foreach (skew_o[i]) begin
        chk_bit(skew_o[i], p[0] ^ i[0]);
        chk_bit(pri_o[i], ~(p[0] ^ i[0]));
        chk_bit(red_o[i], p[0] ^ i[0]);
      end
    end
    // clock outputs under every timing select, single edge
    for (int m = 0; m < 4; m++) begin
      rx_timing_select = m[1:0];
      repeat (6) begin
        @(negedge sys_clk);
        #1;
        foreach (clk_t[i]) begin
          chk_bit(clk_t[i], m[1] ? rec_clk[(m == 2) ? 0 : i] : 1'b0);
          chk_bit(clk_c[i], m[1] ? ~rec_clk[(m == 2) ? 0 : i] : 1'b1);
        end
      end
    end
    // dual edge under channel a selection: all lanes copy lane a
    @(negedge sys_clk);
    dual_edge = 1'b1;
    rx_timing_select = 2'h2;
    repeat (6) begin
      @(negedge sys_clk);
      #1;
      foreach (clk_t[i]) chk_bit(clk_t[i] ^ clk_c[0], 1'b1);
    end
    @(negedge sys_clk);
    dual_edge = 1'b0;
    rx_timing_select = 2'h0;
    // status and data rows, rate matching off
    foreach (rows[r]) begin
      tx_fsm = rows[r].f;
      tx_char = mk(rows[r].d, rows[r].k, rows[r].cb, rows[r].db, 1'b0);
      cyc(25);
      for (int i = 0; i < NCH; i++) begin
        chk_byte({5'h0, st(i)}, {5'h0, rows[r].st});
        if (rows[r].chk_d) chk_byte(rx_byte[i], rows[r].d);
      end
    end
    // rate matching modes; reads outpace writes, so only idles can absorb it
    rm_watch(1'b0, 1'b0, FSM_SYNC, 1'b0);
    rm_watch(1'b0, 1'b1, FSM_SYNC, 1'b1);
    rm_watch(1'b0, 1'b1, FSM_RESYNC, 1'b0);
    rm_watch(1'b1, 1'b1, FSM_SYNC, 1'b0);
    // framing shift on every lane: one recovered period wide, caught once each
    @(negedge rec_clk[0]);
    realign = 1'b1;
    @(negedge rec_clk[0]);
    realign = 1'b0;
    cyc(10);
    chk_bit(align_sync_out, 1'b0);
    // sync point on channel a: idles with disparity pattern 0 0 1 1
    for (int k = 0; k < 4; k++) begin
      @(posedge rec_clk[0]);
      tx_char = mk(IDLE_BYTE, 1'b1, 1'b0, 1'b0, k[1]);
    end
    seen = 0;
    while (align_sync_out !== 1'b1 && seen < 200) begin
      @(negedge sys_clk);
      seen++;
    end
    // a timeout counts as a mismatch and falls through to the one report
    if (seen >= 200) begin
      failures++;
    end else begin
      for (int b = 2; b >= 0; b--) begin
        cyc(1);
        chk_bit(align_sync_out, b[0] == 1'b0 ? 1'b0 : 1'b1);
      end
    end
    results();
  end
endmodule // rx_elastic_deskew_rate_match_tb_top
